// ==== logic/sfe_pkg.sv ====
// shared constants for the serial front end device and host ends
package sfe_pkg;
    // instruction codes
    localparam logic [7:0] INSTR_WREN     = 8'h06;
    localparam logic [7:0] INSTR_WRDI     = 8'h04;
    localparam logic [7:0] INSTR_WRSR     = 8'h01;
    localparam logic [7:0] INSTR_RDSR     = 8'h05;
    localparam logic [3:0] INSTR_HI_ZERO  = 4'h0;
    localparam logic [2:0] INSTR_LO_WRITE = 3'h2;
    localparam logic [2:0] INSTR_LO_READ  = 3'h3;

    // byte position inside a sequence
    localparam logic [1:0] IDX_INSTR = 2'h0;
    localparam logic [1:0] IDX_ADDR  = 2'h1;
    localparam logic [1:0] IDX_DATA  = 2'h2;
    localparam logic [2:0] BIT_LAST  = 3'h7;

    // status byte layout: {nv[5:0], wen, busy}, nv[5] is protectPinEnable
    localparam int         STAT_NV_LSB   = 2;
    localparam logic [5:0] STAT_NV_RESET = 6'h00;
    localparam int         NV_PEN_BIT    = 5;

    // storage behind the read and write instructions
    localparam int MEM_DEPTH = 16;

    // programming cycle time and system clock
    localparam int SYS_CLK_MHZ  = 250;
    localparam int PROG_TIME_US = 10;
    localparam int PROG_CYCLES  = PROG_TIME_US * SYS_CLK_MHZ;

    // host serial clock: half period in system clocks
    localparam int HOST_HALF_DIV = 4;
endpackage

// ==== logic/sfe_if.sv ====
// serial link between host and device ends
`timescale 1ns/1ps
interface sfe_if;
    logic chipSelectN;
    logic sck;
    logic si;
    logic so;
    logic soOe;
    logic soLine;

    // undriven output line idles high, as with a pull-up
    assign soLine = soOe ? so : 1'b1;

    modport device (
        input  chipSelectN,
        input  sck,
        input  si,
        output so,
        output soOe
    );

    modport host (
        input  soLine,
        output chipSelectN,
        output sck,
        output si
    );
endinterface

// ==== logic/sfe_device.sv ====
// device end of the serial front end: link logic on sck, programming timer on sys_clk
// Operation
// RULE1 - low chip select selects, high deselects
// RULE2 - select release after valid write starts programming
// RULE3 - programming runs to end regardless of select
// RULE4 - deselected device floats serial output
// RULE5 - ignore bus until select seen falling once
// RULE6 - master keeps select low during sequence
// RULE7 - sample serial input on rising sck
// RULE8 - change serial output only after falling sck
// RULE9 - whole bytes, most significant bit first
// RULE10 - first byte after select is instruction
// RULE11 - read data follows instruction and address
// RULE12 - only modes (0,0) and (1,1) supported
// RULE13 - mode taken from sck at select fall
// RULE14 - master holds sck steady around select fall
// RULE15 - master captures returned bits on rising sck
// RULE16 - last command bit rising, first data falling
// RULE17 - master ends sequence by raising select
// RULE18 - write protect input guards status nv bits
// RULE19 - enabled and protect low rejects status write
// RULE20 - output floats while receiving command bytes
`timescale 1ns/1ps
module sfe_device #(
    parameter int MemDepth   = sfe_pkg::MEM_DEPTH,
    parameter int ProgCycles = sfe_pkg::PROG_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic writeProtectN,
    sfe_if.device     link,
    output logic      progBusy,
    output logic      progDone,
    output logic      linkMode
);
    localparam int AW = $clog2(MemDepth);
    localparam int CW = $clog2(ProgCycles + 1);
    typedef struct packed {
        logic [7:0]    rxSh;
        logic [2:0]    bitCnt;
        logic [1:0]    byteIdx;
        logic [7:0]    instr;
        logic [AW-1:0] addr;
        logic          reading;
        logic          wrote;
        logic [7:0]    txByte;
    } sfe_frame_s;
    typedef struct packed {
        logic                       wpSync1;
        logic                       wpSync2;
        logic                       busySync1;
        logic                       busySync2;
        logic                       wen;
        logic [5:0]                 nv;
        logic                       reqTog;
        logic [MemDepth-1:0][7:0]   mem;
    } sfe_persist_s;
    typedef struct packed {
        logic [7:0] txSh;
        logic       so;
        logic       oe;
    } sfe_out_s;
    typedef struct packed {
        logic          launch1;
        logic          launch2;
        logic          launch3;
        logic          mode1;
        logic          mode2;
        logic [CW-1:0] cnt;
        logic          busy;
        logic          done;
    } sfe_sys_s;
    sfe_frame_s   frame_q;
    sfe_frame_s   frame_d;
    sfe_persist_s persist_q;
    sfe_persist_s persist_d;
    sfe_out_s     out_q;
    sfe_out_s     out_d;
    sfe_sys_s     sys_q;
    sfe_sys_s     sys_d;
    logic         armed_q;
    logic         cpol_q;
    logic         launchTog_q;
    logic         frameRst;
    logic [7:0]   newByte;
    logic [7:0]   statusByte;
    logic         isRead;
    logic         isWrite;
    logic         nvLocked;

    // frame state dies with the select, so a broken sequence never leaks into the next
    assign frameRst   = link.chipSelectN | ~rst_n; // see RULE1
    assign newByte    = {frame_q.rxSh[6:0], link.si}; // see RULE9
    assign statusByte = {persist_q.nv, persist_q.wen, persist_q.busySync2};
    assign isRead     = (frame_q.instr[7:4] == sfe_pkg::INSTR_HI_ZERO)
                      && (frame_q.instr[2:0] == sfe_pkg::INSTR_LO_READ);
    assign isWrite    = (frame_q.instr[7:4] == sfe_pkg::INSTR_HI_ZERO)
                      && (frame_q.instr[2:0] == sfe_pkg::INSTR_LO_WRITE);
    assign nvLocked   = persist_q.nv[sfe_pkg::NV_PEN_BIT] & ~persist_q.wpSync2; // see RULE18

    // select fall: catch clock polarity and arm after power-up
    always_ff @(negedge link.chipSelectN or negedge rst_n)
        if (!rst_n)
        begin
            cpol_q  <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            cpol_q  <= link.sck; // see RULE13
            armed_q <= 1'b1; // see RULE5
        end
    // select rise hands any pending write to the programming timer
    always_ff @(posedge link.chipSelectN or negedge rst_n)
        if (!rst_n)
            launchTog_q <= 1'b0;
        else
            launchTog_q <= persist_q.reqTog; // see RULE2
    always_comb
    begin
        frame_d             = frame_q;
        persist_d           = persist_q;
        persist_d.wpSync1   = writeProtectN;
        persist_d.wpSync2   = persist_q.wpSync1;
        persist_d.busySync1 = sys_q.busy;
        persist_d.busySync2 = persist_q.busySync1;
        if (armed_q)
        begin
            frame_d.rxSh   = newByte; // see RULE7
            frame_d.bitCnt = frame_q.bitCnt + 3'h1;
            if (frame_q.bitCnt == sfe_pkg::BIT_LAST)
            begin
                if (frame_q.byteIdx != sfe_pkg::IDX_DATA)
                    frame_d.byteIdx = frame_q.byteIdx + 2'h1;
                if (frame_q.reading)
                begin
                    // refill for the next outgoing byte, reads run on while clocked
                    if (frame_q.instr == sfe_pkg::INSTR_RDSR)
                        frame_d.txByte = statusByte;
                    else
                    begin
                        frame_d.txByte = persist_q.mem[frame_q.addr];
                        frame_d.addr   = frame_q.addr + AW'(1);
                    end
                end
                else if (frame_q.byteIdx == sfe_pkg::IDX_INSTR)
                begin
                    frame_d.instr = newByte; // see RULE10
                    if (newByte == sfe_pkg::INSTR_WREN)
                        persist_d.wen = 1'b1;
                    if (newByte == sfe_pkg::INSTR_WRDI)
                        persist_d.wen = 1'b0;
                    if (newByte == sfe_pkg::INSTR_RDSR)
                    begin
                        frame_d.reading = 1'b1;
                        frame_d.txByte  = statusByte;
                    end
                end
                else if (frame_q.byteIdx == sfe_pkg::IDX_ADDR)
                begin
                    frame_d.addr = newByte[AW-1:0];
                    if (isRead)
                    begin
                        frame_d.reading = 1'b1; // see RULE11
                        frame_d.txByte  = persist_q.mem[newByte[AW-1:0]];
                        frame_d.addr    = newByte[AW-1:0] + AW'(1);
                    end
                    // locked status write is dropped whole, no cycle is started
                    if (frame_q.instr == sfe_pkg::INSTR_WRSR && persist_q.wen
                        && !persist_q.busySync2 && !nvLocked) // see RULE19
                    begin
                        persist_d.nv     = newByte[7:sfe_pkg::STAT_NV_LSB];
                        persist_d.wen    = 1'b0;
                        persist_d.reqTog = ~persist_q.reqTog;
                        frame_d.wrote    = 1'b1;
                    end
                end
                else if (isWrite && !persist_q.busySync2
                         && (persist_q.wen || frame_q.wrote))
                begin
                    persist_d.mem[frame_q.addr] = newByte;
                    frame_d.addr = frame_q.addr + AW'(1);
                    if (!frame_q.wrote)
                    begin
                        frame_d.wrote    = 1'b1;
                        persist_d.wen    = 1'b0;
                        persist_d.reqTog = ~persist_q.reqTog; // see RULE2
                    end
                end
            end
        end
    end

    always_ff @(posedge link.sck or posedge frameRst)
        if (frameRst)
            frame_q <= '0;
        else
            frame_q <= frame_d;
    always_ff @(posedge link.sck or negedge rst_n)
        if (!rst_n)
        begin
            persist_q    <= '0;
            persist_q.nv <= sfe_pkg::STAT_NV_RESET;
        end
        else
            persist_q <= persist_d;
    // output side: only falling edges move the line; in mode (1,1) the
    // first fall comes before any byte so reading is still clear
    always_comb
    begin
        out_d = out_q;
        if (frame_q.reading) // see RULE20
        begin
            out_d.oe = 1'b1;
            if (frame_q.bitCnt == 3'h0)
            begin
                out_d.so   = frame_q.txByte[7]; // see RULE16
                out_d.txSh = {frame_q.txByte[6:0], 1'b0};
            end
            else
            begin
                out_d.so   = out_q.txSh[7]; // see RULE8
                out_d.txSh = {out_q.txSh[6:0], 1'b0};
            end
        end
    end

    always_ff @(negedge link.sck or posedge frameRst)
        if (frameRst)
            out_q <= '0; // see RULE4
        else
            out_q <= out_d;

    assign link.so   = out_q.so;
    assign link.soOe = out_q.oe;

    // programming timer; never looks at select once started
    always_comb
    begin
        sys_d         = sys_q;
        sys_d.launch1 = launchTog_q;
        sys_d.launch2 = sys_q.launch1;
        sys_d.launch3 = sys_q.launch2;
        sys_d.mode1   = cpol_q; // see RULE12
        sys_d.mode2   = sys_q.mode1;
        sys_d.done    = 1'b0;
        if (sys_q.launch3 != sys_q.launch2)
        begin
            sys_d.busy = 1'b1;
            sys_d.cnt  = CW'(ProgCycles - 1);
        end
        else if (sys_q.busy)
        begin
            if (sys_q.cnt == '0)
            begin
                sys_d.busy = 1'b0;
                sys_d.done = 1'b1;
            end
            else
                sys_d.cnt = sys_q.cnt - CW'(1); // see RULE3
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            sys_q <= '0;
        else
            sys_q <= sys_d;

    assign progBusy = sys_q.busy;
    assign progDone = sys_q.done;
    assign linkMode = sys_q.mode2;
endmodule

// ==== logic/sfe_host.sv ====
// host end of the serial front end: byte exchanges with a divided serial clock
`timescale 1ns/1ps
module sfe_host #(
    parameter int HalfDiv = sfe_pkg::HOST_HALF_DIV
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    sfe_if.host             link,
    input  wire logic       cmdValid,
    output logic            cmdReady,
    input  wire logic [7:0] cmdByte,
    input  wire logic       cmdLast,
    input  wire logic       cmdCpol,
    output logic            rspValid,
    output logic [7:0]      rspByte
);
    localparam int DW = $clog2(HalfDiv + 1);

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_LEAD  = 3'h1,
        ST_SHIFT = 3'h3,
        ST_GAP   = 3'h2,
        ST_TAIL  = 3'h6
    } sfe_state_e;

    typedef struct packed {
        sfe_state_e    st;
        logic [DW-1:0] cnt;
        logic          sck;
        logic          csN;
        logic          si;
        logic [7:0]    txSh;
        logic [7:0]    rxSh;
        logic [3:0]    rises;
        logic          last;
        logic          cpol;
        logic          ready;
        logic          rspValid;
        logic [7:0]    rspByte;
        logic          so1;
        logic          so2;
    } sfe_host_s;

    sfe_host_s host_q;
    sfe_host_s host_d;
    logic      halfEnd;
    logic      sckNext;
    logic [7:0] rxNext;

    assign halfEnd = (host_q.cnt == DW'(HalfDiv - 1));
    assign sckNext = ~host_q.sck;
    assign rxNext  = {host_q.rxSh[6:0], host_q.so2};

    always_comb
    begin
        host_d          = host_q;
        host_d.so1      = link.soLine;
        host_d.so2      = host_q.so1;
        host_d.rspValid = 1'b0;
        host_d.cnt      = halfEnd ? '0 : host_q.cnt + DW'(1);
        unique case (host_q.st)
            ST_IDLE:
            begin
                host_d.sck = host_q.cpol;
                if (cmdValid && host_q.ready)
                begin
                    host_d.txSh  = cmdByte;
                    host_d.si    = cmdByte[7];
                    host_d.last  = cmdLast;
                    host_d.cpol  = cmdCpol;
                    host_d.sck   = cmdCpol;
                    host_d.rises = 4'h0;
                    host_d.ready = 1'b0;
                    host_d.cnt   = '0;
                    host_d.st    = ST_LEAD;
                end
            end
            ST_LEAD:
            begin
                // sck settles a half period before the select fall and a full period after it
                if (halfEnd) // see RULE14
                begin
                    if (host_q.csN)
                    begin
                        host_d.csN = 1'b0;
                    end
                    else
                    begin
                        host_d.st = ST_SHIFT; // see RULE10
                    end
                end
            end
            ST_SHIFT:
            begin
                if (halfEnd)
                begin
                    host_d.sck = sckNext;
                    if (sckNext)
                    begin
                        host_d.rxSh  = rxNext; // see RULE15
                        host_d.rises = host_q.rises + 4'h1;
                    end
                    else if (host_q.rises != 4'h0 && host_q.rises != 4'h8)
                    begin
                        host_d.txSh = {host_q.txSh[6:0], 1'b0};
                        host_d.si   = host_q.txSh[6]; // see RULE9
                    end
                    if (sckNext == host_q.cpol && host_d.rises == 4'h8)
                    begin
                        host_d.rspValid = 1'b1;
                        host_d.rspByte  = sckNext ? rxNext : host_q.rxSh;
                        host_d.st       = host_q.last ? ST_TAIL : ST_GAP;
                        host_d.ready    = ~host_q.last;
                    end
                end
            end
            ST_GAP:
            begin
                // select stays low while waiting for the next byte
                host_d.cnt = '0; // see RULE6
                if (cmdValid && host_q.ready)
                begin
                    host_d.txSh  = cmdByte;
                    host_d.si    = cmdByte[7];
                    host_d.last  = cmdLast;
                    host_d.rises = 4'h0;
                    host_d.ready = 1'b0;
                    host_d.st    = ST_SHIFT;
                end
            end
            ST_TAIL:
            begin
                if (halfEnd)
                begin
                    host_d.csN   = 1'b1; // see RULE17
                    host_d.ready = 1'b1;
                    host_d.st    = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_q       <= '0;
            host_q.st    <= ST_IDLE;
            host_q.csN   <= 1'b1;
            host_q.ready <= 1'b1;
        end
        else
        begin
            host_q <= host_d;
        end
    end

    assign link.chipSelectN = host_q.csN;
    assign link.sck         = host_q.sck;
    assign link.si          = host_q.si;
    assign cmdReady         = host_q.ready;
    assign rspValid         = host_q.rspValid;
    assign rspByte          = host_q.rspByte;
endmodule

// ==== verification/sfe_assertions.sv ====
// concurrent checks on the serial link between host and device ends
`timescale 1ns/1ps
module sfe_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chipSelectN,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic soOe
);
    // rising sck edges seen inside the current frame
    logic [7:0] riseCnt_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            riseCnt_q <= 8'h00;
        end
        else if (chipSelectN)
        begin
            riseCnt_q <= 8'h00;
        end
        else if ($rose(sck))
        begin
            riseCnt_q <= riseCnt_q + 8'h01;
        end
    end

    // sck is a divided sys_clk, so sys_clk sampling sees every edge
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    property p_deselect_float;
        chipSelectN |-> !soOe;
    endproperty
    a_deselect_float: assert property (p_deselect_float)
        else $error("output driven while deselected");

    property p_so_change;
        soOe && $changed(so) |-> $fell(sck);
    endproperty
    a_so_change: assert property (p_so_change)
        else $error("output changed off falling sck");

    property p_oe_start;
        $rose(soOe) |-> $fell(sck) && !chipSelectN && riseCnt_q[2:0] == 3'h0
            && riseCnt_q >= 8'h08;
    endproperty
    a_oe_start: assert property (p_oe_start)
        else $error("output enabled at wrong point");

    property p_sck_hold;
        $fell(chipSelectN) |-> sck == $past(sck, 3) ##1 $stable(sck) [*6];
    endproperty
    a_sck_hold: assert property (p_sck_hold)
        else $error("sck moved around select fall");

    property p_select_end;
        $rose(chipSelectN) |-> $stable(sck) && sck == $past(sck, 2);
    endproperty
    a_select_end: assert property (p_select_end)
        else $error("select released while sck active");

    property p_whole_bytes;
        $rose(chipSelectN) |-> riseCnt_q[2:0] == 3'h0 && riseCnt_q != 8'h00;
    endproperty
    a_whole_bytes: assert property (p_whole_bytes)
        else $error("frame not whole bytes");

    property p_si_stable;
        $rose(sck) && !chipSelectN |-> $stable(si);
    endproperty
    a_si_stable: assert property (p_si_stable)
        else $error("input changed at rising sck");

    property p_so_stands;
        soOe && $rose(sck) |-> $stable(so);
    endproperty
    a_so_stands: assert property (p_so_stands)
        else $error("output changed at rising sck");
endmodule

// ==== verification/spi_slave_serial_front_end_tb.sv ====
// self-checking bench joining host and device ends over the serial link
`timescale 1ns/1ps
module spi_slave_serial_front_end_tb;
    localparam int ProgCycles = 8;
    localparam int MaxCycles  = 20000;
    localparam logic [7:0] CmdWrite = {sfe_pkg::INSTR_HI_ZERO, 1'b0, sfe_pkg::INSTR_LO_WRITE};
    localparam logic [7:0] CmdRead  = {sfe_pkg::INSTR_HI_ZERO, 1'b0, sfe_pkg::INSTR_LO_READ};

    logic       sys_clk;
    logic       rst_n;
    logic       devRstN;
    logic       writeProtectN;
    logic       cmdValid;
    logic       cmdReady;
    logic [7:0] cmdByte;
    logic       cmdLast;
    logic       cmdCpol;
    logic       rspValid;
    logic [7:0] rspByte;
    logic       progBusy;
    logic       progDone;
    logic       linkMode;
    logic [7:0] rd;
    logic       doneSeen;
    int         busyLen;
    int         err_total;
    int         n_checks;
    int         cycleCnt;

    sfe_if link ();

    sfe_device #(.ProgCycles(ProgCycles)) i_sfe_device (
        .sys_clk       (sys_clk),
        .rst_n         (devRstN),
        .writeProtectN (writeProtectN),
        .link          (link),
        .progBusy      (progBusy),
        .progDone      (progDone),
        .linkMode      (linkMode)
    );

    sfe_host i_sfe_host (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .link     (link),
        .cmdValid (cmdValid),
        .cmdReady (cmdReady),
        .cmdByte  (cmdByte),
        .cmdLast  (cmdLast),
        .cmdCpol  (cmdCpol),
        .rspValid (rspValid),
        .rspByte  (rspByte)
    );

    sfe_assertions i_sfe_assertions (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n & devRstN),
        .chipSelectN (link.chipSelectN),
        .sck         (link.sck),
        .si          (link.si),
        .so          (link.so),
        .soOe        (link.soOe)
    );

    always #2 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // a hung handshake ends the run here
    always @(posedge sys_clk)
    begin
        cycleCnt <= cycleCnt + 1;
        if (cycleCnt == MaxCycles)
        begin
            err_total = err_total + 1;
            $display("BAD at %0t: run too long", $time);
            print_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one byte through the host; entered and left at a falling edge
    task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] r);
        int n;
        cmdValid = 1'b1;
        cmdByte  = b;
        cmdLast  = last;
        n = 0;
        while (cmdReady !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        cmdValid = 1'b0;
        n = 0;
        while (rspValid !== 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        r = rspByte;
        if (rspValid !== 1'b1)
        begin
            err_total++;
            $display("BAD at %0t: no byte returned", $time);
        end
    endtask

    task automatic cmd1(input logic [7:0] b);
        logic [7:0] r;
        xfer(b, 1'b1, r);
    endtask

    task automatic rdsr(input logic [7:0] exp);
        logic [7:0] r;
        xfer(sfe_pkg::INSTR_RDSR, 1'b0, r);
        xfer(8'h00, 1'b1, r);
        check(r, exp);
    endtask

    // bounded wait for a programming cycle, then its length in cycles
    task automatic wait_prog(output int len);
        int n;
        len = 0;
        n = 0;
        while (progBusy !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk);
            n++;
        end
        while (progBusy === 1'b1 && len < 100)
        begin
            @(negedge sys_clk);
            len++;
        end
        // the end pulse stands in the cycle right after busy drops
        doneSeen = progDone;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        devRstN = 1'b0;
        writeProtectN = 1'b1;
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        cmdLast = 1'b0;
        cmdCpol = 1'b0;
        err_total = 0;
        n_checks = 0;
        cycleCnt = 0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        devRstN = 1'b1;
        // device reset after select fell: that frame must be ignored
        fork
            xfer(sfe_pkg::INSTR_RDSR, 1'b0, rd);
            begin
                repeat (7) @(negedge sys_clk);
                devRstN = 1'b0;
                repeat (2) @(negedge sys_clk);
                devRstN = 1'b1;
            end
        join
        xfer(8'h00, 1'b1, rd);
        check(rd, 8'hFF);
        $display("test unarmed done");
        for (int m = 0; m < 2; m++)
        begin
            cmdCpol = m[0];
            rdsr(8'h00);
            cmd1(sfe_pkg::INSTR_WREN);
            rdsr(8'h02);
            check({7'h00, linkMode}, {7'h00, m[0]});
            cmd1(sfe_pkg::INSTR_WRDI);
        end
        $display("test modes done");
        cmdCpol = 1'b0;
        cmd1(sfe_pkg::INSTR_WREN);
        xfer(CmdWrite, 1'b0, rd);
        xfer(8'h03, 1'b0, rd);
        xfer(8'hA5, 1'b0, rd);
        xfer(8'h5A, 1'b1, rd);
        // select toggles again while the cycle runs
        fork
            wait_prog(busyLen);
            rdsr(8'h00);
        join
        check(busyLen[7:0], 8'(ProgCycles));
        check({7'h00, doneSeen}, 8'h01);
        xfer(CmdRead, 1'b0, rd);
        xfer(8'h03, 1'b0, rd);
        xfer(8'h00, 1'b0, rd);
        check(rd, 8'hA5);
        xfer(8'h00, 1'b1, rd);
        check(rd, 8'h5A);
        // no write enable: no programming cycle, data kept
        xfer(CmdWrite, 1'b0, rd);
        xfer(8'h03, 1'b0, rd);
        xfer(8'h11, 1'b1, rd);
        wait_prog(busyLen);
        check(busyLen[7:0], 8'h00);
        check({7'h00, doneSeen}, 8'h00);
        xfer(CmdRead, 1'b0, rd);
        xfer(8'h03, 1'b0, rd);
        xfer(8'h00, 1'b1, rd);
        check(rd, 8'hA5);
        $display("test write done");
        cmd1(sfe_pkg::INSTR_WREN);
        xfer(sfe_pkg::INSTR_WRSR, 1'b0, rd);
        xfer(8'h80, 1'b1, rd);
        wait_prog(busyLen);
        rdsr(8'h80);
        writeProtectN = 1'b0;
        cmd1(sfe_pkg::INSTR_WREN);
        xfer(sfe_pkg::INSTR_WRSR, 1'b0, rd);
        xfer(8'h84, 1'b1, rd);
        wait_prog(busyLen);
        check(busyLen[7:0], 8'h00);
        check({7'h00, doneSeen}, 8'h00);
        rdsr(8'h82);
        writeProtectN = 1'b1;
        xfer(sfe_pkg::INSTR_WRSR, 1'b0, rd);
        xfer(8'h04, 1'b1, rd);
        wait_prog(busyLen);
        rdsr(8'h04);
        $display("test protect done");
        print_verdict();
    end
endmodule
